// >>> rrt_access_front.sv
// Remote port front end: validity sampling, select capture and core clock pacing.
//
// Contract
// - Each T-state start samples whether the remote access was valid in the T-state before.
// - In held-read and quick-posted-write modes sampling resumes at the first T-state start after acknowledge has been registered.
// - An end sample followed one T-state later by a start sample makes a new access that reuses the select.
// - Select high targets the control register, select low the space its bits choose.
// - Select is captured once per access and reused if a new access starts inside the window.
// - A reused select gives the right target only when it matches the new access.
// - The 1.5 T-state window opens at the very sample that sees the previous end.
// - In held-write mode select is captured for the next access when write pending rises.
// - In held-write mode an access starting within half a T-state of that rise is not recaptured.
// - With speed select at 0 the core and the clock output both run at oscillator rate.
// - With speed select at 1 the clock output stays at oscillator rate and the core halves it.
// - Window timing counts oscillator cycles in half T-states: two halves per cycle at full speed, one at half speed.
// - With no new access 1.5 T-states after an end (2 at full speed), select is captured afresh next time.
`timescale 1ns/100ps
module rrt_access_front (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic core_speed_select_i,
	input wire logic [1:0] mode_i,
	input wire logic access_valid_i,
	input wire logic access_write_i,
	input wire logic reg_select_i,
	input wire logic transfer_acknowledge_i,
	input wire logic write_pending_flag_i,
	input wire logic [rrt_pkg::RRT_CTRL_W-1:0] write_data_i,
	output logic core_tick_o,
	output logic clock_out_tick_o,
	output logic access_start_o,
	output logic access_end_o,
	output logic select_reused_o,
	output logic sel_ctrl_o,
	output logic sel_mem_o,
	output logic [rrt_pkg::RRT_SPACE_W-1:0] mem_space_o,
	output logic [rrt_pkg::RRT_CTRL_W-1:0] remote_interface_control_reg
);
	rrt_pkg::rrt_mode_t mode;
	logic tick;
	logic valid_q;
	logic ack_seen;
	logic wpend_q;
	logic armed;
	logic sel_q;
	logic [rrt_pkg::RRT_CTRL_W-1:0] ctrl;
	logic win_busy;
	logic win_expire;

	assign mode = rrt_pkg::rrt_mode_t'(mode_i);

	// Core clock pacing: at half speed a T-state spans two oscillator cycles.
	wire next_tick = core_speed_select_i ? !tick : 1'b1;
	wire [rrt_pkg::RRT_HALF_W-1:0] halves_step = core_speed_select_i ?
		rrt_pkg::RRT_HALVES_HALF_SPEED : rrt_pkg::RRT_HALVES_FULL_SPEED;

	// Modes that hold the sample until acknowledge has been seen.
	wire held_mode = (mode == rrt_pkg::RRT_MODE_HELD_READ) ||
		(mode == rrt_pkg::RRT_MODE_QUICK_POSTED_WRITE);
	wire held_write = (mode == rrt_pkg::RRT_MODE_HELD_WRITE);

	// Before acknowledge the access is taken as still valid, which is why a
	// fast remote end can cost up to one extra T-state of rest.
	wire hold_off = held_mode && valid_q && !ack_seen;
	wire sample_en = tick && !hold_off;

	// A start is a low-to-high change between two samples; back-to-back
	// samples that both read valid never make a second start.
	wire start_w = sample_en && access_valid_i && !valid_q;
	wire end_w = sample_en && !access_valid_i && valid_q;

	// Write pending rising in held-write mode captures select for the next access.
	wire wp_rise = held_write && write_pending_flag_i && !wpend_q;

	// Capture only when armed; inside a window the old select is reused.
	wire start_capture = start_w && armed && !wp_rise;
	wire capture_w = start_capture || wp_rise;
	wire reuse_w = start_w && !start_capture && !wp_rise;
	wire effective_sel = capture_w ? reg_select_i : sel_q;

	// Route the access: high to the control register, low to memory space.
	wire ctrl_write = start_w && effective_sel && access_write_i;
	wire [rrt_pkg::RRT_CTRL_W-1:0] next_ctrl = ctrl_write ? write_data_i : ctrl;
	wire [rrt_pkg::RRT_SPACE_W-1:0] next_space =
		next_ctrl[rrt_pkg::RRT_SPACE_LSB +: rrt_pkg::RRT_SPACE_W];

	// Window loads: an end opens 1.5 T-states, a pending rise half a T-state.
	wire win_load = end_w || wp_rise;
	wire [rrt_pkg::RRT_HALF_W-1:0] win_halves = wp_rise ?
		rrt_pkg::RRT_WPEND_HALVES : rrt_pkg::RRT_REARM_HALVES;
	// A start inside the window consumes it, so a later expiry cannot re-arm.
	wire win_cancel = start_w;

	// Arming: cleared by a capture or by an end, set when a window runs out.
	// The timer is still busy in its expiry cycle, so busy must not block the set.
	wire next_armed = (capture_w || win_load) ? 1'b0 :
		(win_expire ? 1'b1 : (win_busy ? 1'b0 : armed));

	rrt_half_timer #(
		.W(rrt_pkg::RRT_HALF_W)
	) u_window (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.load_i(win_load),
		.load_halves_i(win_halves),
		.cancel_i(win_cancel),
		.step_i(halves_step),
		.busy_o(win_busy),
		.expire_o(win_expire)
	);

	// Core tick and the oscillator-rate clock output marker.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tick <= 1'b0;
			clock_out_tick_o <= 1'b0;
		end else begin
			tick <= next_tick;
			clock_out_tick_o <= 1'b1;
		end
	end

	// Validity sample and acknowledge tracking.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			valid_q <= 1'b0;
			ack_seen <= 1'b0;
			wpend_q <= 1'b0;
		end else begin
			if (sample_en) begin
				valid_q <= access_valid_i;
			end
			ack_seen <= (end_w || start_w) ? 1'b0 :
				(ack_seen || (valid_q && transfer_acknowledge_i));
			wpend_q <= write_pending_flag_i;
		end
	end

	// Select capture and arming.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			armed <= 1'b1;
			sel_q <= 1'b0;
		end else begin
			armed <= next_armed;
			sel_q <= effective_sel;
		end
	end

	// Registered outputs and the control register itself.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl <= rrt_pkg::RRT_CTRL_RESET;
			access_start_o <= 1'b0;
			access_end_o <= 1'b0;
			select_reused_o <= 1'b0;
			sel_ctrl_o <= 1'b0;
			sel_mem_o <= 1'b0;
			mem_space_o <= '0;
		end else begin
			ctrl <= next_ctrl;
			access_start_o <= start_w;
			access_end_o <= end_w;
			select_reused_o <= reuse_w;
			sel_ctrl_o <= effective_sel;
			sel_mem_o <= !effective_sel;
			mem_space_o <= next_space;
		end
	end

	assign core_tick_o = tick;
	assign remote_interface_control_reg = ctrl;

	// Checks on the sampling, capture and clock pacing behaviour.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_quiet3;
		(!start_w && !wp_rise)[*3];
	endsequence

	sequence s_pend_then_start;
		wp_rise ##1 start_w;
	endsequence

	a_sample_on_tick: assert property (
		!$past(sample_en) |-> $stable(valid_q))
		else $error("Validity sample changed off a T-state boundary.");

	a_hold_before_ack: assert property (
		hold_off |=> valid_q && !access_end_o)
		else $error("Held mode ended an access before acknowledge.");

	a_one_access_merge: assert property (
		valid_q ##1 valid_q |=> !access_start_o)
		else $error("Continuous validity produced a second start.");

	a_route_exclusive: assert property (
		access_start_o |-> (sel_mem_o != sel_ctrl_o))
		else $error("Access routed to both or neither target.");

	a_select_reused: assert property (
		reuse_w |=> (sel_ctrl_o == $past(sel_q)) && select_reused_o)
		else $error("Select was recaptured inside the rest window.");

	a_window_opens: assert property (
		end_w && !wp_rise |=> !armed)
		else $error("Rest window did not open at the end sample.");

	a_rearm_after: assert property (
		end_w ##1 s_quiet3 |=> armed)
		else $error("Select capture did not re-arm after the window.");

	a_pend_capture: assert property (
		wp_rise |=> sel_ctrl_o == $past(reg_select_i))
		else $error("Select not captured when write pending rose.");

	a_pend_no_recap: assert property (
		s_pend_then_start |-> !capture_w)
		else $error("Select recaptured within half a T-state of pending rise.");

	a_half_speed: assert property (
		core_speed_select_i && tick |=> !tick && clock_out_tick_o)
		else $error("Half speed core tick did not skip a cycle.");

	a_full_speed: assert property (
		!core_speed_select_i |=> tick && clock_out_tick_o)
		else $error("Full speed core tick missed a cycle.");

endmodule

// >>> rrt_half_timer.sv
// Down counter of half T-states that pulses when its window runs out.
`timescale 1ns/100ps
module rrt_half_timer #(
	parameter int W = 3
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_halves_i,
	input wire logic cancel_i,
	input wire logic [W-1:0] step_i,
	output logic busy_o,
	output logic expire_o
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	wire running = (count != '0);
	wire last_step = running && (count <= step_i);

	// Expiry is suppressed when a reload or cancel lands in the same cycle.
	assign expire_o = last_step && !load_i && !cancel_i;
	assign busy_o = running;
	assign next_count = load_i ? load_halves_i :
		cancel_i ? '0 :
		last_step ? '0 :
		running ? count - step_i : count;

	// Each cycle removes one or two halves, so a window never ends early.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule

// >>> rrt_pkg.sv
// Shared constants for the remote port access and rest-time front end.
package rrt_pkg;

	// Access modes of the remote port.
	typedef enum logic [1:0] {
		RRT_MODE_PLAIN,
		RRT_MODE_HELD_READ,
		RRT_MODE_QUICK_POSTED_WRITE,
		RRT_MODE_HELD_WRITE
	} rrt_mode_t;

	// Core clock period and the far-end timing allowances, in ns.
	localparam int RRT_CLK_PERIOD_NS = 100;
	localparam int RRT_SETUP_NS = 23;
	localparam int RRT_HOLD_NS = 10;
	// Least separation beyond one T-state, rounded up to whole cycles.
	localparam int RRT_REST_EXTRA_CYCLES =
		(RRT_SETUP_NS + RRT_HOLD_NS + RRT_CLK_PERIOD_NS - 1) / RRT_CLK_PERIOD_NS;

	// Windows are counted in half T-states.
	localparam int RRT_HALF_W = 3;
	localparam logic [RRT_HALF_W-1:0] RRT_HALVES_FULL_SPEED = 3'h2;
	localparam logic [RRT_HALF_W-1:0] RRT_HALVES_HALF_SPEED = 3'h1;
	localparam logic [RRT_HALF_W-1:0] RRT_REARM_HALVES = 3'h3;
	localparam logic [RRT_HALF_W-1:0] RRT_WPEND_HALVES = 3'h1;

	// Control register layout and reset value.
	localparam int RRT_CTRL_W = 8;
	localparam int RRT_SPACE_LSB = 0;
	localparam int RRT_SPACE_W = 2;
	localparam logic [RRT_CTRL_W-1:0] RRT_CTRL_RESET = 8'h00;

endpackage

// >>> rrt_remote_host.sv
// Behavioural remote host that presents accesses to the port.
`timescale 1ns/100ps
module rrt_remote_host (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic sel_i,
	input wire logic wr_i,
	input wire logic [rrt_pkg::RRT_CTRL_W-1:0] data_i,
	output logic valid_o = 1'b0,
	output logic write_o = 1'b0,
	output logic select_o = 1'b0,
	output logic [rrt_pkg::RRT_CTRL_W-1:0] data_o = 8'h00
);
	// Lines move just after an edge; idle data shows the inverse of the last value.
	always_ff @(posedge clk_i) begin
		valid_o <= req_i;
		select_o <= sel_i;
		write_o <= req_i ? wr_i : ~write_o;
		data_o <= req_i ? data_i : ~data_o;
	end
endmodule

// >>> tb_remote_access_rest_timing.sv
// Self-checking bench for the remote port front end.
`timescale 1ns/100ps
module tb_remote_access_rest_timing;
	logic clk, reset_i, speed, ack, wpend, req, psel, pwr;
	logic [1:0] mode;
	logic [7:0] pdata, wdata, ctrl;
	logic valid, wr, sel, tick, ctick, start, stop, reused, s_ctrl, s_mem;
	logic [1:0] space;
	int num_errors = 0;
	int n_checks = 0;
	int n_start = 0;
	int n_end = 0;
	int n_reuse = 0;

	rrt_remote_host i_rrt_remote_host (.clk_i(clk), .req_i(req), .sel_i(psel), .wr_i(pwr),
		.data_i(pdata), .valid_o(valid), .write_o(wr), .select_o(sel), .data_o(wdata));
	rrt_access_front i_rrt_access_front (.clk_i(clk), .reset_i(reset_i),
		.core_speed_select_i(speed), .mode_i(mode), .access_valid_i(valid),
		.access_write_i(wr), .reg_select_i(sel), .transfer_acknowledge_i(ack),
		.write_pending_flag_i(wpend), .write_data_i(wdata), .core_tick_o(tick),
		.clock_out_tick_o(ctick), .access_start_o(start), .access_end_o(stop),
		.select_reused_o(reused), .sel_ctrl_o(s_ctrl), .sel_mem_o(s_mem),
		.mem_space_o(space), .remote_interface_control_reg(ctrl));

	// Pulses are counted, so a test need not land on their exact cycle.
	always @(posedge clk) begin
		if (start === 1'b1) n_start++;
		if (stop === 1'b1) n_end++;
		if (reused === 1'b1) n_reuse++;
	end

	task automatic summarize();
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	// One access; a following call leaves the valid line low for one cycle only.
	task automatic go(input logic s, input logic w, input logic [7:0] d, input int n);
		@(posedge clk);
		req <= 1'b1;
		psel <= s;
		pwr <= w;
		pdata <= d;
		cyc(n);
		req <= 1'b0;
	endtask

	task automatic t_clock();
		logic a;
		chk("clock_out", 8'h01, {7'h0, ctick});
		a = tick;
		cyc(1);
		chk("tick_full", 8'h01, {7'h0, a & tick});
		@(posedge clk) speed <= 1'b1;
		cyc(3);
		a = tick;
		cyc(1);
		chk("tick_half", 8'h01, {7'h0, a ^ tick});
		chk("clock_out_half", 8'h01, {7'h0, ctick});
		@(posedge clk) speed <= 1'b0;
	endtask

	task automatic t_ctrl();
		int s;
		s = n_start;
		go(1'b1, 1'b1, 8'h02, 3);
		cyc(4);
		chk("starts", 8'(s + 1), 8'(n_start));
		chk("sel_ctrl", 8'h01, {7'h0, s_ctrl});
		chk("ctrl", 8'h02, ctrl);
		chk("space", 8'h02, {6'h0, space});
	endtask

	task automatic t_reuse();
		int s;
		int r;
		cyc(6);
		r = n_reuse;
		go(1'b0, 1'b0, 8'h5A, 3);
		cyc(4);
		chk("sel_mem", 8'h01, {7'h0, s_mem});
		chk("fresh", 8'(r), 8'(n_reuse));
		cyc(4);
		s = n_start;
		go(1'b1, 1'b0, 8'h00, 3);
		go(1'b0, 1'b0, 8'h00, 3);
		cyc(4);
		chk("starts", 8'(s + 2), 8'(n_start));
		chk("reused", 8'(r + 1), 8'(n_reuse));
		chk("stale_sel", 8'h01, {7'h0, s_ctrl});
	endtask

	// Two trials at opposite tick phases: one gap is seen, the other is merged.
	task automatic t_merge();
		int s;
		@(posedge clk) speed <= 1'b1;
		cyc(6);
		s = n_start;
		go(1'b1, 1'b1, 8'h01, 4);
		go(1'b1, 1'b1, 8'h01, 4);
		cyc(7);
		go(1'b1, 1'b1, 8'h01, 4);
		go(1'b1, 1'b1, 8'h01, 4);
		cyc(10);
		chk("merged", 8'(s + 3), 8'(n_start));
		@(posedge clk) speed <= 1'b0;
	endtask

	task automatic t_held();
		int e;
		int s;
		// Both acknowledge-held modes; the end must wait for acknowledge.
		for (int m = 1; m <= 2; m++) begin
			@(posedge clk) mode <= 2'(m);
			cyc(4);
			e = n_end;
			go(1'b0, 1'b0, 8'h00, 4);
			cyc(5);
			chk("no_end_before_ack", 8'(e), 8'(n_end));
			ack <= 1'b1;
			cyc(1);
			ack <= 1'b0;
			cyc(5);
			chk("ends", 8'(e + 1), 8'(n_end));
		end
		@(posedge clk) mode <= 2'h3;
		psel <= 1'b1;
		cyc(3);
		chk("before_rise", 8'h00, {7'h0, s_ctrl});
		wpend <= 1'b1;
		cyc(3);
		chk("at_rise", 8'h01, {7'h0, s_ctrl});
		s = n_start;
		go(1'b1, 1'b0, 8'h00, 3);
		wpend <= 1'b0;
		cyc(4);
		chk("held_start", 8'(s + 1), 8'(n_start));
		mode <= 2'h0;
	endtask

	// The clock toggles every half period.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Run limit of 3000 cycles is far above the roughly 160 cycles the tests need.
	initial begin
		#(100 * 3000);
		num_errors++;
		summarize();
	end

	initial begin
		reset_i = 1'b1;
		speed = 1'b0;
		mode = 2'h0;
		ack = 1'b0;
		wpend = 1'b0;
		req = 1'b0;
		psel = 1'b0;
		pwr = 1'b0;
		pdata = 8'h00;
		cyc(12);
		reset_i <= 1'b0;
		cyc(2);
		t_clock();
		t_ctrl();
		t_reuse();
		t_merge();
		t_held();
		summarize();
	end
endmodule
